// ===== pkg/cspr_map.svh
// register offsets, field positions and timing constants of the supply, and the controller's wishbone register offsets
`ifndef CSPR_MAP_SVH
`define CSPR_MAP_SVH
`define CSPR_CMD_OPERATION   16'h0000
`define CSPR_CMD_OUTPUT_VOLTAGE_SETPOINT    16'h0020
`define CSPR_CMD_OUTPUT_CURRENT_SETPOINT    16'h0030
`define CSPR_CMD_MFR_DATE    16'h0086
`define CSPR_CMD_SER_DATE    16'h0087
`define CSPR_CMD_SER_SEQ     16'h0088
`define CSPR_CMD_SCALING     16'h00c0
`define CSPR_CMD_STATUS      16'h00c1
`define CSPR_CMD_CONFIG      16'h00c2
`define CSPR_LEN_READ        4'h2
`define CSPR_LEN_WRITE       4'h4
`define CSPR_LEN_STATUS      4'h4
`define CSPR_LEN_WIDE        4'h8
`define CSPR_LEN_OPER        4'h3
`define CSPR_CFG_CAN_CTRL    0
`define CSPR_CFG_OPI_LO      1
`define CSPR_CFG_OPI_HI      2
`define CSPR_CFG_POL_LO      8
`define CSPR_CFG_POL_HI      9
`define CSPR_CFG_SAVE_OFF    10
`define CSPR_CFG_RESET       16'h0002
`define CSPR_CFG_MASK        16'h0407 | 16'h0300
`define CSPR_OPI_OFF         2'b00
`define CSPR_OPI_ON          2'b01
`define CSPR_OPI_PREV        2'b10
`define CSPR_POL_NOW         2'b00
`define CSPR_POL_1MIN        2'b01
`define CSPR_POL_10MIN       2'b10
`define CSPR_ST_MASTER       0
`define CSPR_ST_DC_GOOD      1
`define CSPR_ST_PFC_GOOD     2
`define CSPR_ST_DUMMY        4
`define CSPR_ST_INIT         5
`define CSPR_ST_NVM_ERR      6
`define CSPR_CLK_HZ          64'd20000000
`define CSPR_BIT_RATE_BPS    64'd250000
`define CSPR_BIT_CYCLES      (`CSPR_CLK_HZ / `CSPR_BIT_RATE_BPS)
`define CSPR_FRAME_OVH_BITS  8'd67
`define CSPR_DELAY1_S        64'd60
`define CSPR_DELAY10_S       64'd600
`define CSPR_REQ_ID_HI       21'h000c01
`define CSPR_RSP_ID_HI       21'h000c00
`define CSPR_WB_CTRL         8'h00
`define CSPR_WB_CODE         8'h04
`define CSPR_WB_PARAM        8'h08
`define CSPR_WB_STATUS       8'h0c
`define CSPR_WB_RDATA_LO     8'h10
`define CSPR_WB_RDATA_HI     8'h14
`define CSPR_WB_RLEN         8'h18
`define CSPR_WB_ST_BUSY      0
`define CSPR_WB_ST_DONE      1
`define CSPR_WB_C_START      0
`define CSPR_WB_C_WRITE      1
`endif

// ===== pkg/cspr_pkg.sv
// frame type shared by both ends of the command link, and the controller end's state type
package cspr_pkg;
  typedef struct packed {
    logic        ide;
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cspr_frame_t;
  typedef enum logic [1:0] {CSPR_H_IDLE, CSPR_H_SEND, CSPR_H_WAIT}
    cspr_host_st_t;
endpackage : cspr_pkg

// ===== pkg/cspr_link_if.sv
// frame-level link between controller and supply
`timescale 1ns/1ps
interface cspr_link_if;
  import cspr_pkg::*;
  logic        h2d_valid;
  cspr_frame_t h2d_frame;
  logic        d2h_valid;
  cspr_frame_t d2h_frame;
  modport host (output h2d_valid, output h2d_frame,
                input d2h_valid, input d2h_frame);
  modport dev  (input h2d_valid, input h2d_frame,
                output d2h_valid, output d2h_frame);
endinterface : cspr_link_if

// ===== rtl/cspr_bit_pacer.sv
// holds a frame on the line for its length in bit times
`timescale 1ns/1ps
module cspr_bit_pacer #(
  parameter int BIT_CYCLES = 80
) (
  input  wire logic       ref_clk_i, // clock
  input  wire logic       reset_i,   // sync reset
  input  wire logic       start_i,   // begin a frame
  input  wire logic [7:0] bits_i,    // frame length in bits
  output logic            busy_o,    // frame on the line
  output logic            done_o     // last bit ended
);
  logic [7:0]  bit_q;
  logic [15:0] cyc_q;
  wire         last_cyc = cyc_q == 16'(BIT_CYCLES - 1);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bit_q  <= 8'h00;
      cyc_q  <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        bit_q  <= bits_i;
        cyc_q  <= 16'h0000;
      end else if (busy_o) begin
        cyc_q <= last_cyc ? 16'h0000 : cyc_q + 16'h0001;
        if (last_cyc) begin
          bit_q <= bit_q - 8'h01;
          if (bit_q == 8'h01) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule : cspr_bit_pacer

// ===== rtl/cspr_supply_end.sv
// supply end: command register set answering over the link
// Function
// - date register returns six ASCII digits, first first
// - serial: date digits, then sequence digits
// - byte 0: voltage factor low, current high
// - factor codes: zero unsupported, 4..9 multipliers
// - byte 1: input voltage low, fan high
// - temperature byte 2, input current byte 3
// - status bit 0 shows parallel master
// - bits 1, 2 show secondary and primary good
// - bit 4 shows dummy load active
// - bit 5 shows initialization phase
// - bit 6 shows nonvolatile access error
// - unsupported and undefined bits read zero
// - config bit 0 selects link setpoints
// - config bits 1-2 pick power-up preset
// - config high bits 0-1 pick save delay
// - config high bit 2 blocks all saving
// - code and parameter sent low byte first
// - read request two bytes, reply code plus data
// - 250 kbit/s extended identifier frames
// - controller writes voltage as 0.01 counts
// - raw count times reported factor gives quantity
`timescale 1ns/1ps
`include "cspr_map.svh"
module cspr_supply_end #(
  parameter logic [47:0] MFR_DATE   = 48'h313830313031, // "180101"
  parameter logic [47:0] SER_DATE   = 48'h313830313031,
  parameter logic [47:0] SER_SEQ    = 48'h303030303031,
  parameter logic [3:0]  F_VOUT     = 4'h5,
  parameter logic [3:0]  F_IOUT     = 4'h5,
  parameter logic [3:0]  F_VIN      = 4'h6,
  parameter logic [3:0]  F_FAN      = 4'h7,
  parameter logic [3:0]  F_TEMP     = 4'h6,
  parameter logic [3:0]  F_IIN      = 4'h6,
  parameter bit          DUMMY_SUPP = 1'b1,
  parameter logic [35:0] DELAY1_CYC =
    36'(`CSPR_DELAY1_S * `CSPR_CLK_HZ),
  parameter logic [35:0] DELAY10_CYC =
    36'(`CSPR_DELAY10_S * `CSPR_CLK_HZ)
) (
  input  wire logic        ref_clk_i,         // clock
  input  wire logic        reset_i,           // sync reset
  cspr_link_if.dev         link,              // link to controller
  input  wire logic [7:0]  unit_addr_i,       // assigned address
  input  wire logic [15:0] nv_config_i,       // stored setup word
  input  wire logic        nv_operation_i,    // stored on/off
  input  wire logic [15:0] nv_vout_i,         // stored voltage count
  input  wire logic [15:0] nv_iout_i,         // stored current count
  input  wire logic        parallel_master_i, // parallel master
  input  wire logic        secondary_output_good_i, // dc good
  input  wire logic        primary_stage_good_i,    // pfc good
  input  wire logic        dummy_load_active_i,     // load on
  input  wire logic        init_phase_i,      // initializing
  input  wire logic        nvm_access_error_i,// nvm failed
  input  wire logic [15:0] analog_vout_i,     // analog voltage
  input  wire logic [15:0] analog_iout_i,     // analog current
  input  wire logic        analog_on_i,       // remote on pin
  output logic [15:0]      output_voltage_setpoint_o, // voltage
  output logic [15:0]      output_current_setpoint_o, // current
  output logic             output_on_o,       // output enable
  output logic [15:0]      unit_setup_word_o, // setup word
  output logic             save_req_o,        // save pulse
  output logic [15:0]      save_vout_o,       // voltage to save
  output logic [15:0]      save_iout_o,       // current to save
  output logic             save_operation_o   // on/off to save
);
  import cspr_pkg::*;

  function automatic logic [47:0] ascii_order(input logic [47:0] v);
    ascii_order = {v[7:0], v[15:8], v[23:16],
                   v[31:24], v[39:32], v[47:40]};
  endfunction : ascii_order

  logic [15:0] config_q;
  logic [15:0] vout_q;
  logic [15:0] iout_q;
  logic        oper_q;
  logic        boot_q;
  logic        dirty_q;
  logic [35:0] quiet_q;
  cspr_frame_t rsp_q;
  logic        tx_start_q;
  logic        tx_busy;
  logic        tx_done;

  wire [15:0] rx_code  = link.h2d_frame.data[15:0];
  wire [15:0] rx_param = link.h2d_frame.data[31:16];
  wire rx_ok = link.h2d_valid && link.h2d_frame.ide
             && link.h2d_frame.id[7:0] == unit_addr_i;
  wire rx_wr = rx_ok && link.h2d_frame.dlc == `CSPR_LEN_WRITE;
  wire rx_rd = rx_ok && link.h2d_frame.dlc == `CSPR_LEN_READ
             && !tx_busy && !tx_start_q;

  // byte0 {current, voltage}, byte1 {fan, ac voltage}, byte2 temperature, byte3 input current, rest reserved
  wire [47:0] scaling = {16'h0000, 4'h0, F_IIN, 4'h0, F_TEMP,
                         F_FAN, F_VIN, F_IOUT, F_VOUT};
  // each code is 0 or 4..9 and scales the raw count

  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[`CSPR_ST_MASTER]  = parallel_master_i;
    status[`CSPR_ST_DC_GOOD] = secondary_output_good_i;
    status[`CSPR_ST_PFC_GOOD] = primary_stage_good_i;
    status[`CSPR_ST_DUMMY]   = DUMMY_SUPP && dummy_load_active_i;
    status[`CSPR_ST_INIT]    = init_phase_i;
    status[`CSPR_ST_NVM_ERR] = nvm_access_error_i;
  end

  logic        rd_hit;
  logic [3:0]  rd_len;
  logic [47:0] rd_data;
  always_comb begin
    rd_hit  = 1'b1;
    rd_len  = `CSPR_LEN_WIDE;
    rd_data = 48'h0;
    case (rx_code)
      `CSPR_CMD_MFR_DATE: rd_data = ascii_order(MFR_DATE);
      `CSPR_CMD_SER_DATE: rd_data = ascii_order(SER_DATE);
      `CSPR_CMD_SER_SEQ:  rd_data = ascii_order(SER_SEQ);
      `CSPR_CMD_SCALING:  rd_data = scaling;
      `CSPR_CMD_STATUS: begin
        rd_len  = `CSPR_LEN_STATUS;
        rd_data = {32'h0, status};
      end
      `CSPR_CMD_CONFIG: begin
        rd_len  = `CSPR_LEN_STATUS;
        rd_data = {32'h0, config_q};
      end
      `CSPR_CMD_OUTPUT_VOLTAGE_SETPOINT: begin
        rd_len  = `CSPR_LEN_STATUS;
        rd_data = {32'h0, vout_q};
      end
      `CSPR_CMD_OUTPUT_CURRENT_SETPOINT: begin
        rd_len  = `CSPR_LEN_STATUS;
        rd_data = {32'h0, iout_q};
      end
      `CSPR_CMD_OPERATION: begin
        rd_len  = `CSPR_LEN_OPER;
        rd_data = {47'h0, oper_q};
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // writes of the setting commands; anything else is ignored
  wire wr_cfg  = rx_wr && rx_code == `CSPR_CMD_CONFIG;
  wire wr_vout = rx_wr && rx_code == `CSPR_CMD_OUTPUT_VOLTAGE_SETPOINT;
  wire wr_iout = rx_wr && rx_code == `CSPR_CMD_OUTPUT_CURRENT_SETPOINT;
  wire wr_oper = rx_wr && rx_code == `CSPR_CMD_OPERATION;
  wire [15:0] cfg_new = rx_param & (`CSPR_CFG_MASK);
  wire changed = (wr_vout && rx_param != vout_q)
               || (wr_iout && rx_param != iout_q)
               || (wr_oper && rx_param[0] != oper_q);

  wire [1:0] nv_opi = nv_config_i[`CSPR_CFG_OPI_HI:`CSPR_CFG_OPI_LO];
  logic boot_oper;
  always_comb begin
    case (nv_opi)
      `CSPR_OPI_OFF:  boot_oper = 1'b0;
      `CSPR_OPI_ON:   boot_oper = 1'b1;
      `CSPR_OPI_PREV: boot_oper = nv_operation_i;
      default:        boot_oper = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      boot_q   <= 1'b1;
      config_q <= `CSPR_CFG_RESET;
      vout_q   <= 16'h0000;
      iout_q   <= 16'h0000;
      oper_q   <= 1'b1;
    end else if (boot_q) begin
      // restore after release, not under reset
      boot_q   <= 1'b0;
      config_q <= nv_config_i & (`CSPR_CFG_MASK);
      vout_q   <= nv_vout_i;
      iout_q   <= nv_iout_i;
      oper_q   <= boot_oper;
    end else begin
      if (wr_cfg)  config_q <= cfg_new;
      if (wr_vout) vout_q   <= rx_param;
      if (wr_iout) iout_q   <= rx_param;
      if (wr_oper) oper_q   <= rx_param[0];
    end
  end

  // save policy: quiet timer restarts on every change
  wire [1:0] policy = config_q[`CSPR_CFG_POL_HI:`CSPR_CFG_POL_LO];
  wire save_off = config_q[`CSPR_CFG_SAVE_OFF];
  logic due;
  always_comb begin
    case (policy)
      `CSPR_POL_NOW:   due = 1'b1;
      `CSPR_POL_1MIN:  due = quiet_q >= DELAY1_CYC;
      `CSPR_POL_10MIN: due = quiet_q >= DELAY10_CYC;
      default:         due = 1'b0;
    endcase
  end
  wire save_now = dirty_q && !changed && due && !save_off;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dirty_q    <= 1'b0;
      quiet_q    <= 36'h0;
      save_req_o <= 1'b0;
    end else begin
      save_req_o <= save_now;
      // a change in the save cycle keeps the flag set
      dirty_q    <= changed || (dirty_q && !save_now);
      if (changed) quiet_q <= 36'h0;
      else if (dirty_q && quiet_q != DELAY10_CYC)
        quiet_q <= quiet_q + 36'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      output_voltage_setpoint_o <= 16'h0000;
      output_current_setpoint_o <= 16'h0000;
      output_on_o               <= 1'b0;
      unit_setup_word_o         <= `CSPR_CFG_RESET;
      save_vout_o               <= 16'h0000;
      save_iout_o               <= 16'h0000;
      save_operation_o          <= 1'b0;
    end else begin
      if (config_q[`CSPR_CFG_CAN_CTRL]) begin
        output_voltage_setpoint_o <= vout_q;
        output_current_setpoint_o <= iout_q;
        output_on_o               <= oper_q;
      end else begin
        output_voltage_setpoint_o <= analog_vout_i;
        output_current_setpoint_o <= analog_iout_i;
        output_on_o               <= analog_on_i;
      end
      unit_setup_word_o <= config_q;
      save_vout_o       <= vout_q;
      save_iout_o       <= iout_q;
      save_operation_o  <= oper_q;
    end
  end

  // response: code then data, own address in the low id byte
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rsp_q      <= '0;
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= 1'b0;
      if (rx_rd && rd_hit && !boot_q) begin
        rsp_q.ide  <= 1'b1;
        rsp_q.id   <= {`CSPR_RSP_ID_HI, unit_addr_i};
        rsp_q.dlc  <= rd_len;
        rsp_q.data <= {rd_data, rx_code};
        tx_start_q <= 1'b1;
      end
    end
  end

  cspr_bit_pacer #(
    .BIT_CYCLES(int'(`CSPR_BIT_CYCLES))
  ) u_pacer (
    .ref_clk_i(ref_clk_i),
    .reset_i  (reset_i),
    .start_i  (tx_start_q),
    .bits_i   (`CSPR_FRAME_OVH_BITS + {1'b0, rsp_q.dlc, 3'b000}),
    .busy_o   (tx_busy),
    .done_o   (tx_done)
  );

  assign link.d2h_valid = tx_done;
  assign link.d2h_frame = rsp_q;
endmodule : cspr_supply_end

// ===== rtl/cspr_ctrl_end.sv
// controller end: wishbone-driven request sender and reply catcher
`timescale 1ns/1ps
`include "cspr_map.svh"
module cspr_ctrl_end (
  input  wire logic        ref_clk_i, // clock
  input  wire logic        reset_i,   // sync reset
  cspr_link_if.host        link,      // link to supply
  input  wire logic        wb_cyc_i,  // wishbone cycle
  input  wire logic        wb_stb_i,  // wishbone strobe
  input  wire logic        wb_we_i,   // write enable
  input  wire logic [7:0]  wb_adr_i,  // byte address
  input  wire logic [3:0]  wb_sel_i,  // byte selects
  input  wire logic [31:0] wb_dat_i,  // write data
  output logic [31:0]      wb_dat_o,  // read data
  output logic             wb_ack_o   // acknowledge
);
  import cspr_pkg::*;
  cspr_host_st_t st_q;
  logic [7:0]  addr_q;
  logic        write_q;
  logic [15:0] code_q;
  logic [15:0] param_q;
  logic        done_q;
  logic [47:0] rdata_q;
  logic [3:0]  rlen_q;
  cspr_frame_t req_q;
  logic        tx_start_q;
  logic        tx_done;

  wire acc  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr   = acc && wb_we_i;
  wire rd   = acc && !wb_we_i;
  wire wr_ctrl  = wr && wb_adr_i == `CSPR_WB_CTRL && wb_sel_i[0];
  wire wr_code  = wr && wb_adr_i == `CSPR_WB_CODE;
  wire wr_param = wr && wb_adr_i == `CSPR_WB_PARAM;
  wire wr_stat  = wr && wb_adr_i == `CSPR_WB_STATUS && wb_sel_i[0];
  wire start = wr_ctrl && wb_dat_i[`CSPR_WB_C_START] && st_q == CSPR_H_IDLE;
  wire [15:0] rx_code = link.d2h_frame.data[15:0];
  wire rx_hit = link.d2h_valid && link.d2h_frame.ide
              && link.d2h_frame.id[7:0] == addr_q && rx_code == code_q;
  wire fin = (st_q == CSPR_H_SEND && tx_done && write_q)
           || (st_q == CSPR_H_WAIT && rx_hit);

  logic [31:0] rmux;
  always_comb begin
    case (wb_adr_i)
      `CSPR_WB_CTRL:     rmux = {16'h0, addr_q, 6'h0, write_q, 1'b0};
      `CSPR_WB_CODE:     rmux = {16'h0, code_q};
      `CSPR_WB_PARAM:    rmux = {16'h0, param_q};
      `CSPR_WB_STATUS:   rmux = {30'h0, done_q, st_q != CSPR_H_IDLE};
      `CSPR_WB_RDATA_LO: rmux = rdata_q[31:0];
      `CSPR_WB_RDATA_HI: rmux = {16'h0, rdata_q[47:32]};
      `CSPR_WB_RLEN:     rmux = {28'h0, rlen_q};
      default:           rmux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rd ? rmux : 32'h0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_q       <= CSPR_H_IDLE;
      addr_q     <= 8'h00;
      write_q    <= 1'b0;
      code_q     <= 16'h0000;
      param_q    <= 16'h0000;
      done_q     <= 1'b0;
      rdata_q    <= 48'h0;
      rlen_q     <= 4'h0;
      req_q      <= '0;
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= start;
      if (st_q == CSPR_H_IDLE) begin
        if (wr_code)  code_q  <= wb_dat_i[15:0];
        if (wr_param) param_q <= wb_dat_i[15:0];
        if (wr_ctrl) begin
          addr_q  <= wb_dat_i[15:8];
          write_q <= wb_dat_i[`CSPR_WB_C_WRITE];
        end
      end
      // a completion in the clearing cycle is kept
      done_q <= fin || (done_q && !(wr_stat && wb_dat_i[`CSPR_WB_ST_DONE]));
      if (rx_hit && st_q == CSPR_H_WAIT) begin
        rdata_q <= link.d2h_frame.data[63:16];
        rlen_q  <= link.d2h_frame.dlc;
      end
      case (st_q)
        CSPR_H_IDLE: if (start) begin
          st_q      <= CSPR_H_SEND;
          req_q.ide <= 1'b1;
          req_q.id  <= {`CSPR_REQ_ID_HI, wb_dat_i[15:8]};
          req_q.dlc <= wb_dat_i[`CSPR_WB_C_WRITE] ? `CSPR_LEN_WRITE
                                                  : `CSPR_LEN_READ;
          req_q.data <= {32'h0, param_q, code_q};
        end
        CSPR_H_SEND: if (tx_done) begin
          st_q <= write_q ? CSPR_H_IDLE : CSPR_H_WAIT;
        end
        CSPR_H_WAIT: if (rx_hit || (wr_ctrl && !wb_dat_i[`CSPR_WB_C_START]))
          st_q <= CSPR_H_IDLE;
        default: st_q <= CSPR_H_IDLE;
      endcase
    end
  end

  cspr_bit_pacer #(
    .BIT_CYCLES(int'(`CSPR_BIT_CYCLES))
  ) u_pacer (
    .ref_clk_i(ref_clk_i),
    .reset_i  (reset_i),
    .start_i  (tx_start_q),
    .bits_i   (`CSPR_FRAME_OVH_BITS + {1'b0, req_q.dlc, 3'b000}),
    .busy_o   (),
    .done_o   (tx_done)
  );

  assign link.h2d_valid = tx_done;
  assign link.h2d_frame = req_q;
endmodule : cspr_ctrl_end

// ===== tb/cspr_link_checker.sv
// link-level assertions between controller end and supply end
`timescale 1ns/1ps
`include "cspr_map.svh"
module cspr_link_checker
  import cspr_pkg::*;
(
  input wire logic        ref_clk_i, // clock
  input wire logic        reset_i,   // sync reset
  input wire logic        h2d_valid, // request ends
  input wire cspr_frame_t h2d_frame, // request frame
  input wire logic        d2h_valid, // reply ends
  input wire cspr_frame_t d2h_frame  // reply frame
);
  logic [15:0] code_q;
  logic [7:0]  addr_q;
  wire  [15:0] rsp_code = d2h_frame.data[15:0];

  // remember the last read request so the reply can be matched
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      code_q <= 16'h0000;
      addr_q <= 8'h00;
    end else if (h2d_valid && h2d_frame.dlc == `CSPR_LEN_READ) begin
      code_q <= h2d_frame.data[15:0];
      addr_q <= h2d_frame.id[7:0];
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_req_ext_fmt: assert property (h2d_valid |-> h2d_frame.ide)
    else $error("request frame not extended format");
  a_rsp_ext_fmt: assert property (d2h_valid |-> d2h_frame.ide &&
    d2h_frame.id[28:8] == `CSPR_RSP_ID_HI)
    else $error("reply frame identifier wrong");
  a_req_len_ok: assert property (h2d_valid |->
    h2d_frame.dlc inside {`CSPR_LEN_READ, `CSPR_LEN_WRITE})
    else $error("request length not 2 or 4");
  a_rsp_code_echo: assert property (d2h_valid |-> rsp_code == code_q)
    else $error("reply code differs from request");
  a_rsp_own_addr: assert property (d2h_valid |->
    d2h_frame.id[7:0] == addr_q)
    else $error("reply address differs from request");
  a_wide_len: assert property (d2h_valid &&
    rsp_code inside {16'h0086, 16'h0087, 16'h0088, 16'h00c0}
    |-> d2h_frame.dlc == `CSPR_LEN_WIDE)
    else $error("six byte reply length wrong");
  a_word_len: assert property (d2h_valid &&
    rsp_code inside {16'h00c1, 16'h00c2, 16'h0020, 16'h0030}
    |-> d2h_frame.dlc == `CSPR_LEN_STATUS)
    else $error("word reply length wrong");
  a_req_spacing: assert property (h2d_valid |=> !h2d_valid [*8])
    else $error("request frames too close");
  a_rsp_not_early: assert property (h2d_valid |->
    !d2h_valid ##1 !d2h_valid [*8])
    else $error("reply came without frame time");
  a_scale_rsv: assert property (d2h_valid && rsp_code == 16'h00c0
    |-> d2h_frame.data[63:48] == 16'h0000 &&
    d2h_frame.data[39:36] == 4'h0 && d2h_frame.data[47:44] == 4'h0)
    else $error("scaling reserved bits not zero");
  a_status_rsv: assert property (d2h_valid && rsp_code == 16'h00c1
    |-> d2h_frame.data[31:23] == 9'h000 && !d2h_frame.data[19])
    else $error("status undefined bits not zero");
endmodule : cspr_link_checker

// ===== tb/can_supply_command_registers_test.sv
// end-to-end bench: wishbone commands through both link ends
`timescale 1ns/1ps
`include "cspr_map.svh"
module can_supply_command_registers_test;
  import cspr_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic [7:0]  wb_adr    = 8'h00;
  logic [31:0] wb_dat    = 32'h0;
  logic [3:0]  wb_sel    = 4'h0;
  logic [31:0] wb_q, rd_lo, rd_hi, rd_len, sw;
  logic [7:0]  uaddr;
  logic [5:0]  st_in;
  logic [15:0] an_v, an_i, nv_v, nv_i, prm, pri, nv_cfg;
  logic        an_on, nv_op, opx;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, save_req, on_o, sv_op;
  wire  [15:0] vset, setup, iset, sv_v, sv_i;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          n_save     = 0;
  int          seed       = 33;
  cspr_frame_t req_q;
  localparam logic [47:0] DATE = 48'h323430373135;

  always #25 ref_clk_i = ~ref_clk_i;

  cspr_link_if link ();
  cspr_ctrl_end u_cspr_ctrl_end (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .link(link), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  cspr_supply_end #(.MFR_DATE(DATE), .F_VOUT(4'h5), .F_IOUT(4'h6),
    .F_VIN(4'h7), .F_FAN(4'h8), .F_TEMP(4'h9), .F_IIN(4'h4),
    .DELAY1_CYC(36'h64), .DELAY10_CYC(36'h12c)) u_cspr_supply_end (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(link),
    .unit_addr_i(uaddr), .nv_config_i(nv_cfg), .nv_operation_i(nv_op),
    .nv_vout_i(nv_v), .nv_iout_i(nv_i), .parallel_master_i(st_in[0]),
    .secondary_output_good_i(st_in[1]), .primary_stage_good_i(st_in[2]),
    .dummy_load_active_i(st_in[3]), .init_phase_i(st_in[4]),
    .nvm_access_error_i(st_in[5]), .analog_vout_i(an_v),
    .analog_iout_i(an_i), .analog_on_i(an_on),
    .output_voltage_setpoint_o(vset), .output_current_setpoint_o(iset),
    .output_on_o(on_o), .unit_setup_word_o(setup), .save_req_o(save_req),
    .save_vout_o(sv_v), .save_iout_o(sv_i), .save_operation_o(sv_op));
  cspr_link_checker u_cspr_link_checker (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .h2d_valid(link.h2d_valid),
    .h2d_frame(link.h2d_frame), .d2h_valid(link.d2h_valid),
    .d2h_frame(link.d2h_frame));

  always @(posedge ref_clk_i) begin
    if (link.h2d_valid === 1'b1)
      req_q <= link.h2d_frame;
    if (save_req === 1'b1)
      n_save++;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_sel <= 4'hf;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
    if (n >= 50) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : wb

  // one command on the link, then collect the reply registers
  task automatic cmd(input logic wr, input logic [15:0] code,
                     input logic [15:0] p);
    int n;
    wb(1'b1, `CSPR_WB_CODE, {16'h0, code}, wb_q);
    wb(1'b1, `CSPR_WB_PARAM, {16'h0, p}, wb_q);
    wb(1'b1, `CSPR_WB_CTRL, {16'h0, uaddr, 6'h0, wr, 1'b1}, wb_q);
    n = 0;
    do begin
      wb(1'b0, `CSPR_WB_STATUS, 32'h0, wb_q);
      n++;
    end while (wb_q[0] !== 1'b0 && n < 20000);
    if (n >= 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
    if (!wr)
      chk({31'h0, wb_q[1]}, 32'h1);
    chk({16'h0, req_q.data[15:0]}, {16'h0, code});
    chk({28'h0, req_q.dlc}, wr ? 32'h4 : 32'h2);
    chk({24'h0, req_q.id[7:0]}, {24'h0, uaddr});
    if (wr)
      chk({16'h0, req_q.data[31:16]}, {16'h0, p});
    wb(1'b1, `CSPR_WB_STATUS, 32'h2, wb_q);
    wb(1'b0, `CSPR_WB_RDATA_LO, 32'h0, rd_lo);
    wb(1'b0, `CSPR_WB_RDATA_HI, 32'h0, rd_hi);
    wb(1'b0, `CSPR_WB_RLEN, 32'h0, rd_len);
  endtask : cmd

  task automatic rd(input logic [15:0] code, input logic [31:0] lo,
                    input logic [31:0] hi, input logic [31:0] len);
    cmd(1'b0, code, 16'h0);
    chk(rd_lo, lo);
    chk({16'h0, rd_hi[15:0]}, hi);
    chk(rd_len, len);
    $display("test read %h done", code);
  endtask : rd

  initial begin
    repeat (100000) @(posedge ref_clk_i);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    uaddr = 8'($random(seed));
    st_in = 6'h00;
    an_v  = 16'($random(seed));
    an_i  = 16'($random(seed));
    an_on = 1'($random(seed));
    nv_v  = 16'($random(seed));
    nv_i  = 16'($random(seed));
    nv_op = 1'($random(seed));
    nv_cfg = {13'h0, 2'($random(seed)), 1'b0};
    // expected power-up state from the preset field
    opx = nv_cfg[2:1] == `CSPR_OPI_ON ||
          (nv_cfg[2:1] == `CSPR_OPI_PREV && nv_op);
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk({16'h0, vset}, {16'h0, an_v});
    chk({16'h0, iset}, {16'h0, an_i});
    chk({31'h0, on_o}, {31'h0, an_on});
    chk({16'h0, setup}, {16'h0, nv_cfg});
    chk({31'h0, sv_op}, {31'h0, opx});
    $display("test reset done");
    pri = ~nv_i ^ {1'b0, 15'($random(seed))};
    cmd(1'b1, `CSPR_CMD_OUTPUT_CURRENT_SETPOINT, pri);
    repeat (3) @(posedge ref_clk_i);
    chk(32'(n_save), 32'h1);
    chk({16'h0, sv_i}, {16'h0, pri});
    chk({16'h0, sv_v}, {16'h0, nv_v});
    chk({16'h0, iset}, {16'h0, an_i});
    $display("test save done");
    cmd(1'b1, `CSPR_CMD_CONFIG, 16'hffff);
    rd(`CSPR_CMD_CONFIG, 32'h0707, 32'h0, 32'h4);
    chk({16'h0, setup}, 32'h0707);
    chk({16'h0, iset}, {16'h0, pri});
    chk({31'h0, on_o}, {31'h0, opx});
    prm = 16'($random(seed));
    cmd(1'b1, `CSPR_CMD_OUTPUT_VOLTAGE_SETPOINT, prm);
    repeat (3) @(posedge ref_clk_i);
    chk({16'h0, vset}, {16'h0, prm});
    chk(32'(n_save), 32'h1);
    $display("test setpoint done");
    for (int k = 0; k < 4; k++)
      sw[8*k +: 8] = DATE[47-8*k -: 8];
    rd(`CSPR_CMD_MFR_DATE, sw, {16'h0, DATE[7:0], DATE[15:8]}, 32'h8);
    rd(`CSPR_CMD_SCALING, 32'h04098765, 32'h0, 32'h8);
    @(posedge ref_clk_i);
    st_in <= 6'($random(seed));
    @(posedge ref_clk_i);
    rd(`CSPR_CMD_STATUS, {25'h0, st_in[5:3], 1'b0, st_in[2:0]},
       32'h0, 32'h4);
    tally_and_finish();
  end
endmodule : can_supply_command_registers_test
